// *** rtl/irq_pkg.sv ***
package irq_pkg;

  // ------------------------------------------------------------------
  // Link register port
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 10;
  localparam int SRC_N = 6;
  localparam int QUEUE_DEPTH = 4;
  localparam int COUNT_W = 3;

  localparam logic [3:0] REG_QUEUE_DATA = 4'h0;
  localparam logic [3:0] REG_QUEUE_CTRL = 4'h1;
  localparam logic [3:0] REG_LEVEL_LIMIT = 4'h2;
  localparam logic [3:0] REG_FILL_LEVEL = 4'h3;
  localparam logic [3:0] REG_AUTORANGE = 4'h4;
  localparam logic [3:0] REG_ENABLE_MASK = 4'h5;
  localparam logic [3:0] REG_POLARITY_FLIP = 4'h6;
  localparam logic [3:0] REG_OUT_FLIP = 4'h7;
  localparam logic [3:0] REG_PENDING_VIEW = 4'h8;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int SRC_SPACE = 0;
  localparam int SRC_WORD = 1;
  localparam int SRC_UNLOCK = 2;
  localparam int SRC_RANGED = 3;
  localparam int SRC_LEVEL = 4;
  localparam int SRC_ERROR = 5;
  localparam int CTRL_OVER_BIT = 0;
  localparam int CTRL_UNDER_BIT = 1;
  localparam int RANGE_START_BIT = 0;
  localparam int RANGE_UNLOCK_BIT = 0;
  localparam int RANGE_DONE_BIT = 1;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [5:0] FLIP_RST = 6'h00;
  localparam logic [2:0] LIMIT_RST = 3'h4;
  localparam logic [2:0] SPACE_BELOW = 3'h4;

  // ------------------------------------------------------------------
  // Host controller software port
  // ------------------------------------------------------------------
  localparam int SW_ADDR_W = 3;
  localparam int SW_DATA_W = 16;
  localparam logic [2:0] HREG_CMD = 3'h0;
  localparam logic [2:0] HREG_STATUS = 3'h1;
  localparam logic [2:0] HREG_LINK_DATA = 3'h2;
  localparam logic [2:0] HREG_CONFIG = 3'h3;
  localparam logic [2:0] HREG_ENCODER = 3'h4;
  localparam logic [2:0] HREG_SERVED = 3'h5;
  localparam int CMD_ADDR_LSB = 10;
  localparam int CMD_WRITE_BIT = 14;
  localparam int CFG_AUTO_BIT = 0;
  localparam int CFG_HIGH_BIT = 1;
  localparam int CFG_LOW_RATE_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_LATE_BIT = 2;
  localparam int ST_WORD_BIT = 3;
  localparam int ENC_FLIP_BIT = 0;
  localparam int ENC_TRANS_BIT = 1;
  localparam int ENC_WHITE_BIT = 2;
  localparam int ENC_BIPH_BIT = 3;
  localparam int ENC_STD_BIT = 4;
  localparam logic [2:0] CONFIG_RST = 3'h2;
  localparam logic [4:0] ENCODER_RST = 5'h00;

  // ------------------------------------------------------------------
  // Servicing and preamble constants
  // ------------------------------------------------------------------
  localparam int SERVICE_BITS = 24;
  localparam logic [1:0] LOW_RATE_BURST = 2'h3;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] PRE_ONES = 8'hFF;
  localparam logic [7:0] PRE_ALT = 8'h55;

endpackage

// *** rtl/irq_link_if.sv ***
`timescale 1ns/100ps

interface irq_link_if;
  logic [irq_pkg::ADDR_W-1:0] reg_addr;
  logic [irq_pkg::DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [irq_pkg::DATA_W-1:0] reg_rdata;
  logic irq;

  modport device (
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    input reg_rd,
    output reg_rdata,
    output irq
  );

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input reg_rdata,
    input irq
  );
endinterface

// *** rtl/word_queue.sv ***
`timescale 1ns/100ps

module word_queue #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  // State
  output logic [CNT_W-1:0] fill_count,
  output logic overrun,
  output logic underrun
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic full;
  logic empty;
  logic do_push;
  logic do_pop;

  assign full = (count_q == CNT_W'(DEPTH));
  assign empty = (count_q == '0);
  // A pop on an empty queue while a push arrives is still an underrun.
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign overrun = push && full && !do_pop;
  assign underrun = pop && empty;
  assign fill_count = count_q;
  assign head_data = mem_q[rd_ptr_q];

  always_ff @(posedge clock)
  begin
    if (ce && do_push)
    begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (ce)
    begin
      if (do_push)
      begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// *** rtl/irq_device.sv ***
`timescale 1ns/100ps

// Functional notes
// - Space source while queue holds under four
// - Word source while queue holds any word
// - Unlock source; autorange register read clears
// - Ranging done cleared only by new start
// - Level source while fill exceeds limit
// - Raising limit clears level source immediately
// - Queue error; control register read clears
// - Request output is a level, no pulses
// - Edge-only host loops until request drops
// - Host serves within 24 bit periods
// - Inverted word source: one request per three
// - Standard framing preamble: four zero bytes
// - Other modes: DC-free, transition-rich preamble
// - Whitening or plain: 0x55/0xAA; biphase 0x00/0xFF
// - Transition coding: 0xFF if flip equals biphase
// - Per-source invert and mask, output invert
module irq_device #(
  parameter int WIDTH = irq_pkg::DATA_W,
  parameter int DEPTH = irq_pkg::QUEUE_DEPTH
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Link to host
  irq_link_if.device link,
  // Radio side
  input wire logic tx_mode,
  input wire logic radio_push,
  input wire logic [WIDTH-1:0] radio_word,
  input wire logic radio_pop,
  output logic [WIDTH-1:0] radio_out_word,
  // Synthesizer side
  input wire logic synth_lock_lost,
  input wire logic synth_range_done,
  output logic synth_range_start
);

  // ------------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------------
  logic wr_data_hit;
  logic rd_data_hit;
  logic rd_ctrl_hit;
  logic rd_range_hit;
  logic wr_range_start;
  logic [5:0] mask_q;
  logic [5:0] flip_q;
  logic out_flip_q;
  logic [2:0] limit_q;
  logic [WIDTH-1:0] rdata_q;
  logic [WIDTH-1:0] out_word_q;

  assign wr_data_hit = link.reg_wr && (link.reg_addr == irq_pkg::REG_QUEUE_DATA);
  assign rd_data_hit = link.reg_rd && (link.reg_addr == irq_pkg::REG_QUEUE_DATA);
  assign rd_ctrl_hit = link.reg_rd && (link.reg_addr == irq_pkg::REG_QUEUE_CTRL);
  assign rd_range_hit = link.reg_rd && (link.reg_addr == irq_pkg::REG_AUTORANGE);
  assign wr_range_start = link.reg_wr
    && (link.reg_addr == irq_pkg::REG_AUTORANGE)
    && link.reg_wdata[irq_pkg::RANGE_START_BIT];

  // ------------------------------------------------------------------
  // Data queue
  // ------------------------------------------------------------------
  logic q_push;
  logic q_pop;
  logic [WIDTH-1:0] q_in;
  logic [WIDTH-1:0] q_head;
  logic [2:0] fill;
  logic q_over;
  logic q_under;

  // In transmit the host fills and the modulator drains; receive reverses.
  assign q_push = tx_mode ? wr_data_hit : radio_push;
  assign q_in = tx_mode ? link.reg_wdata : radio_word;
  assign q_pop = tx_mode ? radio_pop : rd_data_hit;

  word_queue #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .CNT_W(irq_pkg::COUNT_W)
  ) queue (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .push(q_push),
    .push_data(q_in),
    .pop(q_pop),
    .head_data(q_head),
    .fill_count(fill),
    .overrun(q_over),
    .underrun(q_under)
  );

  // ------------------------------------------------------------------
  // Sticky event flags
  // ------------------------------------------------------------------
  logic over_q;
  logic under_q;
  logic unlock_q;
  logic ranged_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      over_q <= 1'b0;
      under_q <= 1'b0;
    end
    else if (ce)
    begin
      // A new fault in the clearing cycle must not be lost.
      over_q <= q_over || (over_q && !rd_ctrl_hit);
      under_q <= q_under || (under_q && !rd_ctrl_hit);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      unlock_q <= 1'b0;
    end
    else if (ce)
    begin
      unlock_q <= synth_lock_lost || (unlock_q && !rd_range_hit);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ranged_q <= 1'b0;
      synth_range_start <= 1'b0;
    end
    else if (ce)
    begin
      ranged_q <= synth_range_done || (ranged_q && !wr_range_start);
      synth_range_start <= wr_range_start;
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mask_q <= irq_pkg::MASK_RST;
      flip_q <= irq_pkg::FLIP_RST;
      out_flip_q <= 1'b0;
      limit_q <= irq_pkg::LIMIT_RST;
    end
    else if (ce && link.reg_wr)
    begin
      if (link.reg_addr == irq_pkg::REG_ENABLE_MASK)
      begin
        mask_q <= link.reg_wdata[5:0];
      end
      else if (link.reg_addr == irq_pkg::REG_POLARITY_FLIP)
      begin
        flip_q <= link.reg_wdata[5:0];
      end
      else if (link.reg_addr == irq_pkg::REG_OUT_FLIP)
      begin
        out_flip_q <= link.reg_wdata[0];
      end
      else if (link.reg_addr == irq_pkg::REG_LEVEL_LIMIT)
      begin
        limit_q <= link.reg_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Source conditions and request
  // ------------------------------------------------------------------
  logic [5:0] raw_src;
  logic [5:0] pending;
  logic irq_q;

  always_comb
  begin
    raw_src[irq_pkg::SRC_SPACE] = (fill < irq_pkg::SPACE_BELOW);
    raw_src[irq_pkg::SRC_WORD] = (fill != '0);
    raw_src[irq_pkg::SRC_UNLOCK] = unlock_q;
    raw_src[irq_pkg::SRC_RANGED] = ranged_q;
    raw_src[irq_pkg::SRC_LEVEL] = (fill > limit_q);
    raw_src[irq_pkg::SRC_ERROR] = over_q || under_q;
  end

  assign pending = (raw_src ^ flip_q) & mask_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_q <= (|pending) ^ out_flip_q;
    end
  end

  assign link.irq = irq_q;

  // ------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
    end
    else if (ce && link.reg_rd)
    begin
      rdata_q <= '0;
      if (link.reg_addr == irq_pkg::REG_QUEUE_DATA)
      begin
        rdata_q <= q_head;
      end
      else if (link.reg_addr == irq_pkg::REG_QUEUE_CTRL)
      begin
        rdata_q[irq_pkg::CTRL_OVER_BIT] <= over_q;
        rdata_q[irq_pkg::CTRL_UNDER_BIT] <= under_q;
      end
      else if (link.reg_addr == irq_pkg::REG_LEVEL_LIMIT)
      begin
        rdata_q[2:0] <= limit_q;
      end
      else if (link.reg_addr == irq_pkg::REG_FILL_LEVEL)
      begin
        rdata_q[2:0] <= fill;
      end
      else if (link.reg_addr == irq_pkg::REG_AUTORANGE)
      begin
        rdata_q[irq_pkg::RANGE_UNLOCK_BIT] <= unlock_q;
        rdata_q[irq_pkg::RANGE_DONE_BIT] <= ranged_q;
      end
      else if (link.reg_addr == irq_pkg::REG_ENABLE_MASK)
      begin
        rdata_q[5:0] <= mask_q;
      end
      else if (link.reg_addr == irq_pkg::REG_POLARITY_FLIP)
      begin
        rdata_q[5:0] <= flip_q;
      end
      else if (link.reg_addr == irq_pkg::REG_OUT_FLIP)
      begin
        rdata_q[0] <= out_flip_q;
      end
      else if (link.reg_addr == irq_pkg::REG_PENDING_VIEW)
      begin
        rdata_q[5:0] <= pending;
      end
    end
  end

  assign link.reg_rdata = rdata_q;

  // The modulator sees the word that its pop strobe removed.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      out_word_q <= '0;
    end
    else if (ce && tx_mode && radio_pop)
    begin
      out_word_q <= q_head;
    end
  end

  assign radio_out_word = out_word_q;

endmodule

// *** rtl/irq_host.sv ***
`timescale 1ns/100ps

module irq_host #(
  parameter int BIT_CYCLES = 100
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Software port
  input wire logic [irq_pkg::SW_ADDR_W-1:0] sw_addr,
  input wire logic [irq_pkg::SW_DATA_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [irq_pkg::SW_DATA_W-1:0] sw_rdata,
  // Link to device
  irq_link_if.host link
);

  localparam int LATE_CYCLES = irq_pkg::SERVICE_BITS * BIT_CYCLES;
  localparam int LATE_W = $clog2(LATE_CYCLES + 2);

  typedef enum {IDLE, STROBE, WAIT_DATA, SETTLE} state_type;

  // Preamble byte for the active encoder settings.
  function automatic logic [7:0] preamble_byte(input logic [4:0] enc);
    logic flip;
    logic trans;
    logic biph;
    flip = enc[irq_pkg::ENC_FLIP_BIT];
    trans = enc[irq_pkg::ENC_TRANS_BIT];
    biph = enc[irq_pkg::ENC_BIPH_BIT];
    if (enc[irq_pkg::ENC_STD_BIT])
      preamble_byte = irq_pkg::PRE_ZERO;
    else if (enc[irq_pkg::ENC_WHITE_BIT] || !trans)
      preamble_byte = biph && !enc[irq_pkg::ENC_WHITE_BIT] ?
        irq_pkg::PRE_ZERO : irq_pkg::PRE_ALT;
    else
      preamble_byte = (flip == biph) ? irq_pkg::PRE_ONES : irq_pkg::PRE_ZERO;
  endfunction

  state_type state_q;
  logic [2:0] config_q;
  logic [4:0] encoder_q;
  logic [irq_pkg::DATA_W-1:0] link_data_q;
  logic cmd_pend_q;
  logic [14:0] cmd_q;
  logic late_q;
  logic word_q;
  logic [1:0] burst_q;
  logic [LATE_W-1:0] wait_q;
  logic irq_act;
  logic auto_go;
  logic sw_cmd;

  assign irq_act = (link.irq == config_q[irq_pkg::CFG_HIGH_BIT]);
  assign sw_cmd = sw_wr && (sw_addr == irq_pkg::HREG_CMD);
  assign auto_go = config_q[irq_pkg::CFG_AUTO_BIT]
    && (irq_act || burst_q != 2'h0);

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      config_q <= irq_pkg::CONFIG_RST;
      encoder_q <= irq_pkg::ENCODER_RST;
    end
    else if (ce && sw_wr)
    begin
      if (sw_addr == irq_pkg::HREG_CONFIG)
        config_q <= sw_wdata[2:0];
      else if (sw_addr == irq_pkg::HREG_ENCODER)
        encoder_q <= sw_wdata[4:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sw_rdata <= '0;
    end
    else if (ce && sw_rd)
    begin
      sw_rdata <= '0;
      if (sw_addr == irq_pkg::HREG_STATUS)
      begin
        sw_rdata[irq_pkg::ST_BUSY_BIT] <= cmd_pend_q || state_q != IDLE;
        sw_rdata[irq_pkg::ST_IRQ_BIT] <= irq_act;
        sw_rdata[irq_pkg::ST_LATE_BIT] <= late_q;
        sw_rdata[irq_pkg::ST_WORD_BIT] <= word_q;
      end
      else if (sw_addr == irq_pkg::HREG_LINK_DATA)
        sw_rdata[irq_pkg::DATA_W-1:0] <= link_data_q;
      else if (sw_addr == irq_pkg::HREG_CONFIG)
        sw_rdata[2:0] <= config_q;
      else if (sw_addr == irq_pkg::HREG_ENCODER)
        sw_rdata[7:0] <= preamble_byte(encoder_q);
      else if (sw_addr == irq_pkg::HREG_SERVED)
        sw_rdata[1:0] <= burst_q;
    end
  end

  // ------------------------------------------------------------------
  // Link sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= IDLE;
      cmd_pend_q <= 1'b0;
      cmd_q <= '0;
      burst_q <= 2'h0;
      word_q <= 1'b0;
      link_data_q <= '0;
      link.reg_addr <= '0;
      link.reg_wdata <= '0;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
    end
    else if (ce)
    begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      if (sw_cmd)
      begin
        cmd_pend_q <= 1'b1;
        cmd_q <= sw_wdata[14:0];
      end
      if (sw_rd && sw_addr == irq_pkg::HREG_LINK_DATA)
        word_q <= 1'b0;
      case (state_q)
        IDLE:
        begin
          if (cmd_pend_q && !sw_cmd)
          begin
            cmd_pend_q <= 1'b0;
            link.reg_addr <= cmd_q[irq_pkg::CMD_ADDR_LSB +: irq_pkg::ADDR_W];
            link.reg_wdata <= cmd_q[irq_pkg::DATA_W-1:0];
            link.reg_wr <= cmd_q[irq_pkg::CMD_WRITE_BIT];
            link.reg_rd <= !cmd_q[irq_pkg::CMD_WRITE_BIT];
            state_q <= cmd_q[irq_pkg::CMD_WRITE_BIT] ? SETTLE : STROBE;
          end
          else if (auto_go)
          begin
            link.reg_addr <= irq_pkg::REG_QUEUE_DATA;
            link.reg_rd <= 1'b1;
            if (config_q[irq_pkg::CFG_LOW_RATE_BIT])
              burst_q <= (burst_q == 2'h0) ?
                irq_pkg::LOW_RATE_BURST - 2'h1 : burst_q - 2'h1;
            state_q <= STROBE;
          end
        end
        // The device takes the strobe here and answers one cycle later.
        STROBE:
        begin
          state_q <= WAIT_DATA;
        end
        WAIT_DATA:
        begin
          link_data_q <= link.reg_rdata;
          word_q <= 1'b1;
          state_q <= SETTLE;
        end
        // The device request is registered, so give it one cycle to react.
        default:
        begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Service latency watch
  // ------------------------------------------------------------------
  // Late service flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wait_q <= '0;
      late_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!irq_act || link.reg_rd)
        wait_q <= '0;
      else if (wait_q <= LATE_W'(LATE_CYCLES))
        wait_q <= wait_q + 1'b1;
      late_q <= (wait_q == LATE_W'(LATE_CYCLES))
        || (late_q && !(sw_rd && sw_addr == irq_pkg::HREG_STATUS));
    end
  end

endmodule

// *** sim/irq_link_sva.sv ***
`timescale 1ns/100ps

module irq_link_sva (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Link signals
  input wire logic [irq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [irq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  logic [5:0] mask_q;
  logic [2:0] limit_q;
  logic flip_q;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Shadows of the host's writes, so reads can be judged without peeking.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mask_q <= irq_pkg::MASK_RST;
      limit_q <= irq_pkg::LIMIT_RST;
      flip_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == irq_pkg::REG_ENABLE_MASK)
        mask_q <= reg_wdata[5:0];
      if (reg_addr == irq_pkg::REG_LEVEL_LIMIT)
        limit_q <= reg_wdata[2:0];
      if (reg_addr == irq_pkg::REG_OUT_FLIP)
        flip_q <= reg_wdata[0];
    end
  end

  sequence rd_of(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence

  AST_NO_WR_RD: assert property (!(reg_wr && reg_rd))
    else $error("link write and read strobes together");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > irq_pkg::REG_PENDING_VIEW
    |=> reg_rdata == 10'h000) else $error("unmapped read not zero");
  AST_LIMIT_BACK: assert property (rd_of(irq_pkg::REG_LEVEL_LIMIT)
    |=> reg_rdata == {7'h00, $past(limit_q)}) else $error("limit readback");
  AST_FILL_RANGE: assert property (rd_of(irq_pkg::REG_FILL_LEVEL)
    |=> reg_rdata <= 10'h004) else $error("fill level out of range");
  AST_CTRL_BITS: assert property (rd_of(irq_pkg::REG_QUEUE_CTRL)
    |=> reg_rdata[9:2] == 8'h00) else $error("queue status stray bits");
  AST_PEND_MASK: assert property (rd_of(irq_pkg::REG_PENDING_VIEW)
    |=> (reg_rdata & ~{4'h0, $past(mask_q)}) == 10'h000)
    else $error("masked source shows pending");
  AST_IRQ_LEVEL: assert property (rd_of(irq_pkg::REG_PENDING_VIEW)
    |=> irq == ((|reg_rdata) ^ $past(flip_q))) else $error("request level");
  AST_IRQ_MASKED: assert property ((mask_q == 6'h00 && $stable(flip_q))
    [*3] |-> irq == flip_q) else $error("request with all masked");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic tx_mode = 1'b0;
  logic radio_pop = 1'b0;
  logic radio_push = 1'b0;
  logic [9:0] radio_word = 10'h000;
  logic lost = 1'b0;
  logic done = 1'b0;
  logic range_start;
  logic [2:0] sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [9:0] junk;
  int n_fail = 0;
  int compares = 0;
  int starts = 0;

  irq_link_if irq_link_if_inst ();
  irq_device irq_device_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
    .link(irq_link_if_inst), .tx_mode(tx_mode), .radio_push(radio_push),
    .radio_word(radio_word), .radio_pop(radio_pop), .radio_out_word(),
    .synth_lock_lost(lost), .synth_range_done(done),
    .synth_range_start(range_start));
  irq_host #(.BIT_CYCLES(2)) irq_host_inst (.clock(clock), .rst_n(rst_n),
    .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(irq_link_if_inst));
  irq_link_sva irq_link_sva_inst (.clock(clock), .rst_n(rst_n),
    .reg_addr(irq_link_if_inst.reg_addr),
    .reg_wdata(irq_link_if_inst.reg_wdata),
    .reg_wr(irq_link_if_inst.reg_wr), .reg_rd(irq_link_if_inst.reg_rd),
    .reg_rdata(irq_link_if_inst.reg_rdata), .irq(irq_link_if_inst.irq));

  always #5 clock = ~clock;
  always @(posedge clock)
    if (range_start === 1'b1)
      starts++;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task sw_w(input logic [2:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
    @(posedge clock);
  endtask

  task sw_r(input logic [2:0] a, output logic [15:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    @(posedge clock);
    d = sw_rdata;
  endtask

  // One device access through the host's command register.
  task lk(input logic w, input logic [3:0] a, input logic [9:0] d,
          output logic [9:0] r);
    logic [15:0] v;
    sw_w(irq_pkg::HREG_CMD, {1'b0, w, a, d});
    repeat (6) @(posedge clock);
    sw_r(irq_pkg::HREG_LINK_DATA, v);
    r = v[9:0];
  endtask

  task lkc(input logic [3:0] a, input logic [9:0] e);
    logic [9:0] r;
    lk(1'b0, a, 10'h000, r);
    check({6'h00, r}, {6'h00, e});
  endtask

  task push(input logic [9:0] w);
    radio_word <= w;
    radio_push <= 1'b1;
    @(posedge clock);
    radio_push <= 1'b0;
    @(posedge clock);
  endtask

  task t_reset;
    lkc(irq_pkg::REG_LEVEL_LIMIT, 10'h004);
    lkc(irq_pkg::REG_FILL_LEVEL, 10'h000);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h000);
    lkc(4'hF, 10'h000);
    check({15'h0, irq_link_if_inst.irq}, 16'h0000);
    $display("test reset done");
  endtask

  task t_preamble;
    logic [4:0] enc [8];
    logic [7:0] pre [8];
    logic [15:0] v;
    enc = '{5'h10, 5'h04, 5'h00, 5'h08, 5'h02, 5'h03, 5'h0A, 5'h0B};
    pre = '{8'h00, 8'h55, 8'h55, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF};
    for (int i = 0; i < 8; i++)
    begin
      sw_w(irq_pkg::HREG_ENCODER, {11'h000, enc[i]});
      sw_r(irq_pkg::HREG_ENCODER, v);
      check(v, {8'h00, pre[i]});
    end
    $display("test preamble done");
  endtask

  task t_queue;
    lk(1'b1, irq_pkg::REG_ENABLE_MASK, 10'h03F, junk);
    for (int i = 0; i < 4; i++)
      push(10'h101 + 10'(i));
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h002);
    check({15'h0, irq_link_if_inst.irq}, 16'h0001);
    lk(1'b1, irq_pkg::REG_LEVEL_LIMIT, 10'h003, junk);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h012);
    lk(1'b1, irq_pkg::REG_LEVEL_LIMIT, 10'h004, junk);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h002);
    push(10'h1FF);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h022);
    lkc(irq_pkg::REG_QUEUE_CTRL, 10'h001);
    lkc(irq_pkg::REG_QUEUE_CTRL, 10'h000);
    for (int i = 0; i < 4; i++)
    begin
      lkc(irq_pkg::REG_QUEUE_DATA, 10'h101 + 10'(i));
      lkc(irq_pkg::REG_PENDING_VIEW, (i == 3) ? 10'h001 : 10'h003);
    end
    lk(1'b0, irq_pkg::REG_QUEUE_DATA, 10'h000, junk);
    lkc(irq_pkg::REG_QUEUE_CTRL, 10'h002);
    $display("test queue done");
  endtask

  task t_synth;
    lost <= 1'b1;
    @(posedge clock);
    lost <= 1'b0;
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h005);
    lkc(irq_pkg::REG_AUTORANGE, 10'h001);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h001);
    done <= 1'b1;
    @(posedge clock);
    done <= 1'b0;
    lkc(irq_pkg::REG_AUTORANGE, 10'h002);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h009);
    lk(1'b1, irq_pkg::REG_AUTORANGE, 10'h001, junk);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h001);
    check(16'(starts), 16'h0001);
    $display("test synth done");
  endtask

  task t_flip;
    lk(1'b1, irq_pkg::REG_POLARITY_FLIP, 10'h001, junk);
    lkc(irq_pkg::REG_PENDING_VIEW, 10'h000);
    lk(1'b1, irq_pkg::REG_ENABLE_MASK, 10'h000, junk);
    lk(1'b1, irq_pkg::REG_OUT_FLIP, 10'h001, junk);
    check({15'h0, irq_link_if_inst.irq}, 16'h0001);
    lk(1'b1, irq_pkg::REG_OUT_FLIP, 10'h000, junk);
    check({15'h0, irq_link_if_inst.irq}, 16'h0000);
    $display("test flip done");
  endtask

  task t_late;
    logic [15:0] v;
    lk(1'b1, irq_pkg::REG_POLARITY_FLIP, 10'h000, junk);
    lk(1'b1, irq_pkg::REG_ENABLE_MASK, 10'h001, junk);
    repeat (60) @(posedge clock);
    sw_r(irq_pkg::HREG_STATUS, v);
    check(v, 16'h0006);
    lk(1'b1, irq_pkg::REG_ENABLE_MASK, 10'h000, junk);
    sw_r(irq_pkg::HREG_STATUS, v);
    check(v, 16'h0000);
    $display("test late done");
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_preamble;
    t_queue;
    t_synth;
    t_flip;
    t_late;
    report_and_stop;
  end

  // The whole sequence needs well under two thousand cycles.
  initial
  begin
    repeat (8000) @(posedge clock);
    n_fail++;
    report_and_stop;
  end
endmodule
